// ### rtl/ovr_pkg.sv
package ovr_pkg;

	// command codes seen on the management link
	localparam logic [7:0] CODE_OV_REACTION = 8'h41;
	localparam logic [7:0] CODE_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CODE_OV_STATUS = 8'h7A;

	// output_overvoltage_reaction field layout
	localparam int REACT_MSB = 7;
	localparam int REACT_LSB = 6;
	localparam int RETRY_MSB = 5;
	localparam int RETRY_LSB = 3;
	localparam int DELAY_MSB = 2;
	localparam int DELAY_LSB = 0;
	localparam logic [7:0] RESET_OV_REACTION = 8'h80;

	// status byte layout
	localparam int STAT_FAULT_BIT = 7;
	localparam int STAT_ENABLE_BIT = 6;

	// reaction codes
	localparam logic [1:0] REACT_IGNORE = 2'h0;
	localparam logic [1:0] REACT_DELAY = 2'h1;
	localparam logic [1:0] REACT_SHUTDOWN = 2'h2;
	localparam logic [1:0] REACT_HOLD_OFF = 2'h3;

	// restart count codes
	localparam logic [2:0] RETRY_NONE = 3'h0;
	localparam logic [2:0] RETRY_ENDLESS = 3'h7;

	// default length of one delay unit in clk cycles
	localparam int DELAY_UNIT_DEFAULT = 16'h0014;
	localparam int UNIT_W = 16;
	localparam int TIMER_W = 24;

	typedef enum logic [2:0] {
		OVR_RUN = 3'b000,
		OVR_DELAY = 3'b001,
		OVR_BACKOFF = 3'b010,
		OVR_ATTEMPT = 3'b011,
		OVR_LATCHED = 3'b100,
		OVR_HOLD = 3'b101
	} ovr_state_t;

endpackage

// ### rtl/ovr_link_port.sv
`timescale 1ns/100ps
// byte access port on the link clock; hands writes and clears to the core by toggles
module ovr_link_port (
	// link clock domain
	input wire logic link_clk,
	input wire logic link_srst,
	// byte transfers from the host
	input wire logic link_wr,
	input wire logic link_rd,
	input wire logic [7:0] link_code,
	input wire logic [7:0] link_wdata,
	output logic [7:0] link_rdata,
	output logic link_rvalid,
	// toward the core domain
	output logic [7:0] cfg_hold,
	output logic cfg_toggle,
	output logic clear_toggle,
	// levels from the core domain
	input wire logic core_fault,
	input wire logic core_enable
);

	typedef struct packed {
		logic [7:0] cfg;
		logic wr_tog;
		logic clr_tog;
		logic lat_s1;
		logic lat_s2;
		logic en_s1;
		logic en_s2;
		logic [7:0] rdata;
		logic rvalid;
	} ovr_link_t;

	ovr_link_t r;
	ovr_link_t next_r;

	always_comb begin
		next_r = r;
		next_r.lat_s1 = core_fault;
		next_r.lat_s2 = r.lat_s1;
		next_r.en_s1 = core_enable;
		next_r.en_s2 = r.en_s1;
		next_r.rvalid = link_rd;
		next_r.rdata = 8'h00;
		if (link_wr) begin
			if (link_code == ovr_pkg::CODE_OV_REACTION) begin
				next_r.cfg = link_wdata;
				next_r.wr_tog = ~r.wr_tog;
			end
			if (link_code == ovr_pkg::CODE_CLEAR_FAULTS) begin
				next_r.clr_tog = ~r.clr_tog;
			end
			if (link_code == ovr_pkg::CODE_OV_STATUS && link_wdata[ovr_pkg::STAT_FAULT_BIT]) begin
				next_r.clr_tog = ~r.clr_tog;
			end
		end
		if (link_rd) begin
			if (link_code == ovr_pkg::CODE_OV_REACTION) begin
				next_r.rdata = r.cfg;
			end else if (link_code == ovr_pkg::CODE_OV_STATUS) begin
				next_r.rdata[ovr_pkg::STAT_FAULT_BIT] = r.lat_s2;
				next_r.rdata[ovr_pkg::STAT_ENABLE_BIT] = r.en_s2;
			end
		end
	end

	always_ff @(posedge link_clk) begin
		if (link_srst) begin
			r <= '0;
			r.cfg <= ovr_pkg::RESET_OV_REACTION;
		end else begin
			r <= next_r;
		end
	end

	assign link_rdata = r.rdata;
	assign link_rvalid = r.rvalid;
	assign cfg_hold = r.cfg;
	assign cfg_toggle = r.wr_tog;
	assign clear_toggle = r.clr_tog;

endmodule // ovr_link_port

// ### rtl/ovr_fault_response.sv
`timescale 1ns/100ps
module ovr_fault_response #(
	parameter int UNIT_W = ovr_pkg::UNIT_W,
	parameter int TIMER_W = ovr_pkg::TIMER_W
) (
	// core clock and reset
	input wire logic clk,
	input wire logic srst,
	// link clock domain
	input wire logic link_clk,
	input wire logic link_srst,
	input wire logic link_wr,
	input wire logic link_rd,
	input wire logic [7:0] link_code,
	input wire logic [7:0] link_wdata,
	output logic [7:0] link_rdata,
	output logic link_rvalid,
	// converter side
	input wire logic ov_fault_pin,
	input wire logic ctrl_on_pin,
	input wire logic operation_on,
	input wire logic other_fault_shutdown,
	input wire logic [UNIT_W-1:0] delay_unit_cycles,
	// response
	output logic output_enable,
	output logic fault_latched,
	output logic [2:0] attempts_used
);

	typedef struct packed {
		logic fault_s1;
		logic fault_s2;
		logic ctrl_s1;
		logic ctrl_s2;
		logic wr_s1;
		logic wr_s2;
		logic wr_s3;
		logic clr_s1;
		logic clr_s2;
		logic clr_s3;
		logic [7:0] cfg;
		ovr_pkg::ovr_state_t state;
		logic [TIMER_W-1:0] timer;
		logic [2:0] tries;
		logic latched;
		logic en_out;
		logic on_prev;
	} ovr_core_t;

	ovr_core_t r;
	ovr_core_t next_r;

	logic [7:0] cfg_hold;
	logic cfg_toggle;
	logic clear_toggle;

	////////////////////////////////////////////////////////////////////////////////
	// link side byte port

	ovr_link_port u_link (
		.link_clk(link_clk),
		.link_srst(link_srst),
		.link_wr(link_wr),
		.link_rd(link_rd),
		.link_code(link_code),
		.link_wdata(link_wdata),
		.link_rdata(link_rdata),
		.link_rvalid(link_rvalid),
		.cfg_hold(cfg_hold),
		.cfg_toggle(cfg_toggle),
		.clear_toggle(clear_toggle),
		.core_fault(r.latched),
		.core_enable(r.en_out)
	);

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// spacing in clk cycles: unit length shifted by the delay code, minus one for the terminal cycle
	function automatic logic [TIMER_W-1:0] period(input logic [2:0] code, input logic [UNIT_W-1:0] unit);
		logic [TIMER_W-1:0] span;
		span = TIMER_W'(unit) << code;
		if (span == '0) begin
			period = '0;
		end else begin
			period = span - TIMER_W'(1);
		end
	endfunction

	// true when no further attempt is allowed after the ones already used
	function automatic logic retries_spent(input logic [2:0] limit, input logic [2:0] used);
		if (limit == ovr_pkg::RETRY_ENDLESS) begin
			retries_spent = 1'b0;
		end else begin
			retries_spent = (used >= limit);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// next state

	logic [1:0] react;
	logic [2:0] limit;
	logic [TIMER_W-1:0] span;
	logic fault;
	logic on_cmd;
	logic clear_evt;
	logic timer_done;

	always_comb begin
		next_r = r;
		next_r.fault_s1 = ov_fault_pin;
		next_r.fault_s2 = r.fault_s1;
		next_r.ctrl_s1 = ctrl_on_pin;
		next_r.ctrl_s2 = r.ctrl_s1;
		next_r.wr_s1 = cfg_toggle;
		next_r.wr_s2 = r.wr_s1;
		next_r.wr_s3 = r.wr_s2;
		next_r.clr_s1 = clear_toggle;
		next_r.clr_s2 = r.clr_s1;
		next_r.clr_s3 = r.clr_s2;

		react = r.cfg[ovr_pkg::REACT_MSB:ovr_pkg::REACT_LSB];
		limit = r.cfg[ovr_pkg::RETRY_MSB:ovr_pkg::RETRY_LSB];
		span = period(r.cfg[ovr_pkg::DELAY_MSB:ovr_pkg::DELAY_LSB], delay_unit_cycles);
		fault = r.fault_s2;
		on_cmd = r.ctrl_s2 & operation_on & ~other_fault_shutdown;
		timer_done = (r.timer == '0);
		next_r.on_prev = on_cmd;

		// config copy: the link holds the byte steady while its toggle crosses
		if (r.wr_s2 != r.wr_s3) begin
			next_r.cfg = cfg_hold;
		end

		if (!timer_done) begin
			next_r.timer = r.timer - TIMER_W'(1);
		end

		// clear by host status write, clear-faults command, or off then on
		clear_evt = (r.clr_s2 != r.clr_s3) | (on_cmd & ~r.on_prev);

		unique case (r.state)
			ovr_pkg::OVR_RUN: begin
				next_r.en_out = 1'b1;
				if (fault) begin
					unique case (react)
						ovr_pkg::REACT_IGNORE: begin
							next_r.en_out = 1'b1;
						end
						ovr_pkg::REACT_DELAY: begin
							next_r.state = ovr_pkg::OVR_DELAY;
							next_r.timer = span;
						end
						ovr_pkg::REACT_SHUTDOWN: begin
							next_r.en_out = 1'b0;
							next_r.latched = 1'b1;
							if (retries_spent(limit, r.tries)) begin
								next_r.state = ovr_pkg::OVR_LATCHED;
							end else begin
								next_r.state = ovr_pkg::OVR_BACKOFF;
								next_r.timer = span;
							end
						end
						ovr_pkg::REACT_HOLD_OFF: begin
							next_r.en_out = 1'b0;
							next_r.latched = 1'b1;
							next_r.state = ovr_pkg::OVR_HOLD;
						end
					endcase
				end
			end
			ovr_pkg::OVR_DELAY: begin
				if (!fault) begin
					next_r.state = ovr_pkg::OVR_RUN;
				end else if (timer_done) begin
					next_r.en_out = 1'b0;
					next_r.latched = 1'b1;
					if (retries_spent(limit, r.tries)) begin
						next_r.state = ovr_pkg::OVR_LATCHED;
					end else begin
						next_r.state = ovr_pkg::OVR_BACKOFF;
						next_r.timer = span;
					end
				end
			end
			ovr_pkg::OVR_BACKOFF: begin
				next_r.en_out = 1'b0;
				if (timer_done) begin
					next_r.state = ovr_pkg::OVR_ATTEMPT;
					next_r.en_out = 1'b1;
					next_r.timer = span;
					if (r.tries != ovr_pkg::RETRY_ENDLESS) begin
						next_r.tries = r.tries + 3'h1;
					end
				end
			end
			ovr_pkg::OVR_ATTEMPT: begin
				next_r.en_out = 1'b1;
				if (fault) begin
					next_r.en_out = 1'b0;
					if (retries_spent(limit, r.tries)) begin
						next_r.state = ovr_pkg::OVR_LATCHED;
					end else begin
						next_r.state = ovr_pkg::OVR_BACKOFF;
					end
				end else if (timer_done) begin
					next_r.state = ovr_pkg::OVR_RUN;
					next_r.tries = 3'h0;
				end
			end
			ovr_pkg::OVR_LATCHED: begin
				next_r.en_out = 1'b0;
			end
			ovr_pkg::OVR_HOLD: begin
				next_r.en_out = 1'b0;
				if (!fault) begin
					next_r.state = ovr_pkg::OVR_RUN;
					next_r.en_out = 1'b1;
				end
			end
			default: begin
				next_r.state = ovr_pkg::OVR_RUN;
				next_r.en_out = 1'b0;
			end
		endcase

		// fault status: a new fault beats a clear in the same cycle
		if (clear_evt) begin
			if (r.state != ovr_pkg::OVR_HOLD) begin
				next_r.state = ovr_pkg::OVR_RUN;
			end
			next_r.tries = 3'h0;
			next_r.timer = '0;
			if (!(next_r.latched && !r.latched)) begin
				next_r.latched = 1'b0;
			end
		end

		// off command, or another fault shutting the unit down, forces the output off, the state to run and the timer to zero
		if (!on_cmd) begin
			next_r.en_out = 1'b0;
			next_r.state = ovr_pkg::OVR_RUN;
			next_r.timer = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			r <= '0;
			r.cfg <= ovr_pkg::RESET_OV_REACTION;
			r.state <= ovr_pkg::OVR_RUN;
		end else begin
			r <= next_r;
		end
	end

	assign output_enable = r.en_out;
	assign fault_latched = r.latched;
	assign attempts_used = r.tries;

endmodule // ovr_fault_response

// ### bench/ovr_fault_response_monitor.sv
`timescale 1ns/100ps
module ovr_fault_response_monitor (
	// clocks and resets
	input wire logic clk,
	input wire logic srst,
	input wire logic link_clk,
	input wire logic link_srst,
	// link
	input wire logic link_rd,
	input wire logic [7:0] link_rdata,
	input wire logic link_rvalid,
	// converter side
	input wire logic ov_fault_pin,
	input wire logic ctrl_on_pin,
	input wire logic operation_on,
	input wire logic other_fault_shutdown,
	input wire logic output_enable,
	input wire logic fault_latched,
	input wire logic [2:0] attempts_used
);
	logic [4:0] pin_hist;
	logic [4:0] off_hist;
	// recent fault pin and off command history
	always_ff @(posedge clk) begin
		pin_hist <= {pin_hist[3:0], ov_fault_pin};
		off_hist <= {off_hist[3:0], ~ctrl_on_pin | ~operation_on | other_fault_shutdown};
	end
	sequence ctrl_off_s;
		!ctrl_on_pin [*6];
	endsequence
	sequence op_off_s;
		!operation_on [*3];
	endsequence
	////////////////////////////////////////
	chk_reset_clears: assert property (@(posedge clk)
		srst |=> !output_enable && !fault_latched && attempts_used == 3'h0) else $error("reset left state");
	chk_op_off: assert property (@(posedge clk) disable iff (srst)
		op_off_s |-> !output_enable) else $error("output on while commanded off");
	chk_ctrl_off: assert property (@(posedge clk) disable iff (srst)
		ctrl_off_s |-> !output_enable) else $error("output on while pin off");
	chk_other_off: assert property (@(posedge clk) disable iff (srst)
		other_fault_shutdown [*3] |-> !output_enable) else $error("output on during other fault");
	chk_attempt_step: assert property (@(posedge clk) disable iff (srst)
		$changed(attempts_used) |-> attempts_used == $past(attempts_used) + 3'h1 || attempts_used == 3'h0)
		else $error("attempt count jumped");
	chk_latch_cause: assert property (@(posedge clk) disable iff (srst)
		$rose(fault_latched) |-> pin_hist != 5'h00) else $error("latched without fault");
	chk_drop_cause: assert property (@(posedge clk) disable iff (srst)
		$fell(output_enable) && off_hist == 5'h00 |-> pin_hist != 5'h00) else $error("dropped without fault");
	chk_read_answer: assert property (@(posedge link_clk) disable iff (link_srst)
		link_rd |=> link_rvalid) else $error("read got no answer");
	chk_idle_rdata: assert property (@(posedge link_clk) disable iff (link_srst)
		!link_rvalid |-> link_rdata == 8'h00) else $error("read data not zero when idle");
endmodule // ovr_fault_response_monitor

bind ovr_fault_response ovr_fault_response_monitor u_monitor (.clk(clk), .srst(srst), .link_clk(link_clk),
	.link_srst(link_srst), .link_rd(link_rd), .link_rdata(link_rdata), .link_rvalid(link_rvalid),
	.ov_fault_pin(ov_fault_pin), .ctrl_on_pin(ctrl_on_pin), .operation_on(operation_on),
	.other_fault_shutdown(other_fault_shutdown), .output_enable(output_enable), .fault_latched(fault_latched),
	.attempts_used(attempts_used));

// ### bench/ovr_host_model.sv
`timescale 1ns/100ps
module ovr_host_model (
	// link clock
	input wire logic link_clk,
	// byte strobes
	output logic link_wr,
	output logic link_rd,
	output logic [7:0] link_code,
	output logic [7:0] link_wdata
);
	initial begin
		link_wr = 1'b0;
		link_rd = 1'b0;
		link_code = 8'h00;
		link_wdata = 8'hA5;
	end
	////////////////////////////////////////
	// the gap after a write keeps core-side toggles apart
	task automatic put(input logic [7:0] code, input logic [7:0] data);
		@(negedge link_clk);
		link_code = code;
		link_wdata = data;
		link_wr = 1'b1;
		@(negedge link_clk);
		link_wr = 1'b0;
		link_wdata = ~data;
		repeat (60) @(negedge link_clk);
	endtask
	task automatic get(input logic [7:0] code);
		@(negedge link_clk);
		link_code = code;
		link_rd = 1'b1;
		@(negedge link_clk);
		link_rd = 1'b0;
		link_code = ~code;
		repeat (3) @(negedge link_clk);
	endtask
endmodule // ovr_host_model

// ### bench/ovr_fault_response_tb.sv
`timescale 1ns/100ps
module ovr_fault_response_tb;
	logic clk = 1'b0;
	logic link_clk = 1'b0;
	logic srst = 1'b1;
	logic ov_fault_pin = 1'b0;
	logic ctrl_on_pin = 1'b1;
	logic operation_on = 1'b1;
	logic other_fault_shutdown = 1'b0;
	logic link_wr, link_rd, link_rvalid, output_enable, fault_latched, prev_oe;
	logic [7:0] link_code, link_wdata, link_rdata, r8;
	logic [2:0] attempts_used, dcode;
	logic [7:0] exp_q[$];
	logic [15:0] unit = 16'h0004;
	integer seed = 32'hd9e0ff9b;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int rises = 0;
	int last_rise = 0;
	int gap = 0;
	int held;
	always #25 clk = ~clk;
	initial begin
		#0.7;
		forever #3 link_clk = ~link_clk;
	end
	ovr_fault_response u_ovr_fault_response (.clk(clk), .srst(srst), .link_clk(link_clk), .link_srst(srst),
		.link_wr(link_wr), .link_rd(link_rd), .link_code(link_code), .link_wdata(link_wdata),
		.link_rdata(link_rdata), .link_rvalid(link_rvalid), .ov_fault_pin(ov_fault_pin),
		.ctrl_on_pin(ctrl_on_pin), .operation_on(operation_on), .other_fault_shutdown(other_fault_shutdown),
		.delay_unit_cycles(unit), .output_enable(output_enable), .fault_latched(fault_latched),
		.attempts_used(attempts_used));
	ovr_host_model u_host (.link_clk(link_clk), .link_wr(link_wr), .link_rd(link_rd), .link_code(link_code),
		.link_wdata(link_wdata));
	////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
		n_tests++;
		if (seen !== want) begin
			num_errors++;
			$display("unexpected %s: expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic rd(input logic [7:0] code, input logic [7:0] want);
		exp_q.push_back(want);
		u_host.get(code);
	endtask
	task automatic st(input logic [7:0] want);
		rd(ovr_pkg::CODE_OV_STATUS, want);
	endtask
	task automatic cfg(input logic [7:0] v);
		u_host.put(ovr_pkg::CODE_OV_REACTION, v);
		idle(4);
	endtask
	task automatic pin(input logic v, input int n);
		ov_fault_pin = v;
		idle(n);
	endtask
	// read answers stand for one link cycle; look at them between the edges
	always @(negedge link_clk)
		if (link_rvalid === 1'b1)
			check("link read", link_rdata, exp_q.pop_front());
	// counts output enable rises and their spacing; cuts a hang short
	always @(negedge clk) begin
		cycles++;
		if (output_enable === 1'b1 && prev_oe === 1'b0) begin
			gap = cycles - last_rise;
			last_rise = cycles;
			rises++;
		end
		prev_oe = output_enable;
		if (cycles == 6000) begin
			num_errors++;
			stop_test();
		end
	end
	////////////////////////////////////////
	initial begin
		idle(2);
		srst = 1'b0;
		idle(6);
		rd(ovr_pkg::CODE_OV_REACTION, ovr_pkg::RESET_OV_REACTION);
		rd(8'h55, 8'h00);
		st(8'h40);
		r8 = 8'($random(seed));
		cfg(r8);
		rd(ovr_pkg::CODE_OV_REACTION, r8);
		$display("test access done");
		cfg(8'h00);
		pin(1'b1, 30);
		st(8'h40);
		pin(1'b0, 10);
		cfg(8'hC0);
		pin(1'b1, 10);
		check("output enable", 8'(output_enable), 8'h00);
		pin(1'b0, 10);
		check("output enable", 8'(output_enable), 8'h01);
		$display("test ignore and hold done");
		cfg(8'h80);
		pin(1'b1, 10);
		st(8'h80);
		check("fault latched", 8'(fault_latched), 8'h01);
		pin(1'b0, 100);
		st(8'h80);
		u_host.put(ovr_pkg::CODE_CLEAR_FAULTS, 8'h00);
		st(8'h40);
		check("fault latched", 8'(fault_latched), 8'h00);
		$display("test no retry done");
		dcode = 3'h1 + 3'($random(seed) & 1);
		unit = 16'h0004 << ($random(seed) & 1);
		cfg({5'b10010, dcode});
		rises = 0;
		pin(1'b1, 200);
		check("attempts", 8'(rises), 8'h02);
		check("spacing", 8'(gap), 8'(unit << dcode));
		check("attempts used", 8'(attempts_used), 8'h02);
		st(8'h80);
		pin(1'b0, 5);
		u_host.put(ovr_pkg::CODE_OV_STATUS, 8'h80);
		st(8'h40);
		check("attempts used", 8'(attempts_used), 8'h00);
		$display("test two retries done");
		unit = 16'h0004;
		cfg(8'hB9);
		rises = 0;
		pin(1'b1, 150);
		check("endless retry", 8'(rises > 10), 8'h01);
		check("attempts used", 8'(attempts_used), 8'h07);
		other_fault_shutdown = 1'b1;
		idle(3);
		held = rises;
		idle(40);
		check("retry stopped", 8'(rises - held), 8'h00);
		pin(1'b0, 1);
		other_fault_shutdown = 1'b0;
		ctrl_on_pin = 1'b0;
		idle(10);
		ctrl_on_pin = 1'b1;
		idle(20);
		st(8'h40);
		check("attempts used", 8'(attempts_used), 8'h00);
		$display("test endless retry done");
		cfg(8'h43);
		pin(1'b1, 4 + ($random(seed) & 7));
		pin(1'b0, 40);
		st(8'h40);
		pin(1'b1, 20);
		check("output enable", 8'(output_enable), 8'h01);
		idle(40);
		st(8'h80);
		idle(1);
		operation_on = 1'b0;
		pin(1'b0, 10);
		operation_on = 1'b1;
		idle(20);
		st(8'h40);
		$display("test delayed reaction done");
		cfg(8'h89);
		pin(1'b1, 6);
		pin(1'b0, 60);
		check("output enable", 8'(output_enable), 8'h01);
		check("attempts used", 8'(attempts_used), 8'h00);
		$display("test retry success done");
		idle(20);
		stop_test();
	end
endmodule // ovr_fault_response_tb
